/* core/rdsm_detector.v */
// Detector support: peak picker, error outputs, scrambler with lock sequence, sync detector
// and meters. Assumes all inputs come from logic on i_sys_clk, one sample per i_sym_valid.
//
// How it works
// [RULE_01] Peak picker: local max is +3, min is -3.
// [RULE_02] No peak: slicer decision passes through.
// [RULE_03] Picker active in two-level startup, echo-free input.
// [RULE_04] Two 16-bit errors: slicer and equalizer.
// [RULE_05] 23-stage shift register, scrambler or descrambler.
// [RULE_06] Feedback tap set by office or remote role.
// [RULE_07] Descrambler input is detected symbol bits.
// [RULE_08] Two-level: -3 gives 0, +3 gives 1.
// [RULE_09] Four-level: sign then magnitude bit per symbol.
// [RULE_10] Advance once per symbol two-level, twice four-level.
// [RULE_11] Locked scrambler runs with input forced to ones.
// [RULE_12] Lock request bit starts; sequence runs until cleared.
// [RULE_13] Descramble 23 bits, scramble 127, retry without sync.
// [RULE_14] On lock raise sync event, stay scrambling.
// [RULE_15] Sync detector counts agreements over 128 comparisons.
// [RULE_16] Count above threshold declares lock, sets sync flag.
// [RULE_17] Error counter: ones descrambling, agreements scrambling.
// [RULE_18] Error counter saturates 16 bits, stored per interval.
// [RULE_19] Error, inner and noise meters share the two-byte measurement interval.
// [RULE_20] Inner symbol counter, saturating, top byte stored.
// [RULE_21] Noise meter: 32-bit abs error, top half stored.
// [RULE_22] Alarm meter on own timer, compare with limit.
// [RULE_23] Two-level slicer threshold fixed at zero.
// [RULE_24] Low byte read latches matching high byte.
// [RULE_25] Taps 5 and 23 office, 18 and 23 remote.
`include "rdsm_defs.vh"

module rdsm_detector (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_sym_valid,
  input wire [15:0] i_eq_sample,
  input wire [15:0] i_ec_sample,
  input wire [15:0] i_cursor_level,
  input wire i_four_level,
  input wire i_two_level_startup,
  input wire i_central_office,
  input wire i_scramble_mode,
  input wire i_lock_request,
  input wire [15:0] i_alarm_period,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output reg [1:0] o_symbol,
  output reg o_symbol_valid,
  output reg [15:0] o_slicer_err,
  output reg [15:0] o_eq_err,
  output reg o_sync_event,
  output reg o_alarm_event,
  output reg o_locked,
  output reg o_lfsr_scrambling
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function [15:0] ideal_level;
    input [1:0] sym;
    input [15:0] cur;
    reg [15:0] mag;
    begin
      mag = sym[0] ? (cur / 16'h0003) : cur;
      ideal_level = sym[1] ? mag : (16'h0000 - mag);
    end
  endfunction

  // Returns {output bit, next state}.
  function [23:0] lfsr_step;
    input [22:0] s;
    input co;
    input scr;
    input din;
    reg tap;
    reg ob;
    begin
      tap = s[`RDSM_TAP_LONG] ^ (co ? s[`RDSM_TAP_CO] : s[`RDSM_TAP_RT]); // RULE_06 RULE_25
      ob = scr ? (1'b1 ^ tap) : (din ^ tap); // RULE_11
      lfsr_step = {ob, s[21:0], (scr ? ob : din)}; // RULE_05 RULE_07
    end
  endfunction

  // --------------------------------------------------------------------------
  // Slicer and peak picker
  // --------------------------------------------------------------------------
  wire [15:0] abs_x = i_eq_sample[15] ? (16'h0000 - i_eq_sample) : i_eq_sample;
  wire [17:0] three_x = {2'h0, abs_x} + {1'b0, abs_x, 1'b0};
  wire [17:0] two_c = {1'b0, i_cursor_level, 1'b0};
  wire slc_outer = ~i_four_level | (three_x > two_c); // RULE_23
  wire [1:0] slc_sym = {~i_eq_sample[15], ~slc_outer};

  reg [15:0] ec0_q, ec1_q, x1_q;
  reg [1:0] slc1_q;
  reg [1:0] v_q;
  wire picker_on = i_two_level_startup & ~i_four_level;
  // The sample under test is the newest stored one, so its slicer decision and its
  // later neighbour on the input line up with the symbol that is sent out.
  wire signed [15:0] pk_mid = ec0_q;
  wire signed [15:0] pk_old = ec1_q;
  wire signed [15:0] pk_new = i_ec_sample;
  wire pk_max = (pk_mid > pk_old) && (pk_mid > pk_new);
  wire pk_min = (pk_mid < pk_old) && (pk_mid < pk_new);
  reg [1:0] det_sym;

  always @* begin
    det_sym = slc1_q; // RULE_02
    if (picker_on && v_q[1] && pk_max) begin
      det_sym = `RDSM_SYM_POS3; // RULE_01 RULE_03
    end else if (picker_on && v_q[1] && pk_min) begin
      det_sym = `RDSM_SYM_NEG3; // RULE_01 RULE_03
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ec0_q <= 16'h0000;
      ec1_q <= 16'h0000;
      x1_q <= 16'h0000;
      slc1_q <= 2'h0;
      v_q <= 2'h0;
      o_symbol <= 2'h0;
      o_symbol_valid <= 1'b0;
      o_slicer_err <= 16'h0000;
      o_eq_err <= 16'h0000;
    end else if (i_ce) begin
      o_symbol_valid <= 1'b0;
      if (i_sym_valid) begin
        ec1_q <= ec0_q;
        ec0_q <= i_ec_sample;
        x1_q <= i_eq_sample;
        slc1_q <= slc_sym;
        v_q <= {v_q[0], 1'b1};
        if (v_q[0]) begin
          o_symbol <= det_sym;
          o_symbol_valid <= 1'b1;
          o_slicer_err <= x1_q - ideal_level(slc1_q, i_cursor_level); // RULE_04
          o_eq_err <= x1_q - ideal_level(det_sym, i_cursor_level); // RULE_04
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Shift register, lock sequence and sync detector
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_DESC = 4'h2;
  localparam [3:0] ST_SCR = 4'h4;
  localparam [3:0] ST_LOCKED = 4'h8;

  reg [3:0] st_q;
  reg [22:0] lfsr_q;
  reg [7:0] phase_cnt_q, cmp_cnt_q, agr_cnt_q;
  reg [7:0] lock_thresh_q;

  wire seq_scr = (st_q & (ST_SCR | ST_LOCKED)) != 4'h0;
  // A fresh lock request always starts in the descrambler phase, whatever the free mode.
  wire idle_scr = i_scramble_mode & ~i_lock_request;
  wire use_scr = (st_q == ST_IDLE) ? idle_scr : seq_scr; // RULE_13
  wire b_first = o_symbol[1]; // RULE_08 RULE_09
  wire b_second = o_symbol[0]; // RULE_09
  wire [1:0] sym_bits = {b_second, b_first};
  wire [22:0] run_st [0:2];
  wire [22:0] pred_st [0:2];
  wire [1:0] run_out;
  wire [1:0] pred_out;
  assign run_st[0] = lfsr_q;
  assign pred_st[0] = lfsr_q;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_bit
      wire [23:0] run_w = lfsr_step(run_st[gi], i_central_office, use_scr, sym_bits[gi]);
      wire [23:0] pred_w = lfsr_step(pred_st[gi], i_central_office, 1'b1, 1'b0);
      assign run_st[gi + 1] = run_w[22:0];
      assign pred_st[gi + 1] = pred_w[22:0];
      assign run_out[gi] = run_w[23];
      assign pred_out[gi] = pred_w[23];
    end
  endgenerate
  wire [22:0] lfsr_next = i_four_level ? run_st[2] : run_st[1]; // RULE_10
  wire [1:0] nbits = i_four_level ? 2'h2 : 2'h1;
  wire agree_a = (pred_out[0] == b_first);
  wire agree_b = i_four_level & (pred_out[1] == b_second);
  wire [1:0] agree_n = {1'b0, agree_a} + {1'b0, agree_b};
  wire ones_a = ~use_scr & run_out[0];
  wire ones_b = ~use_scr & i_four_level & run_out[1];
  wire [1:0] hit_n = use_scr ? agree_n : ({1'b0, ones_a} + {1'b0, ones_b}); // RULE_17
  wire [7:0] phase_nx = phase_cnt_q + {6'h00, nbits};
  wire [7:0] cmp_nx = cmp_cnt_q + {6'h00, nbits};
  wire [7:0] agr_nx = agr_cnt_q + {6'h00, agree_n};
  wire [7:0] agr_win = (cmp_cnt_q < `RDSM_SYNC_WINDOW) ? agr_nx : agr_cnt_q; // RULE_15

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ST_IDLE;
      lfsr_q <= 23'h000000;
      phase_cnt_q <= 8'h00;
      cmp_cnt_q <= 8'h00;
      agr_cnt_q <= 8'h00;
      o_sync_event <= 1'b0;
      o_locked <= 1'b0;
      o_lfsr_scrambling <= 1'b0;
    end else if (i_ce) begin
      o_sync_event <= 1'b0;
      o_lfsr_scrambling <= use_scr;
      if (!i_lock_request) begin
        st_q <= ST_IDLE; // RULE_12
        o_locked <= 1'b0;
        if (o_symbol_valid) begin
          lfsr_q <= lfsr_next;
        end
      end else if (o_symbol_valid) begin
        lfsr_q <= lfsr_next;
        case (st_q)
          ST_IDLE: begin
            st_q <= ST_DESC; // RULE_12
            phase_cnt_q <= {6'h00, nbits};
          end
          ST_DESC: begin
            phase_cnt_q <= phase_nx;
            if (phase_nx >= `RDSM_DESC_BITS) begin
              st_q <= ST_SCR; // RULE_13
              phase_cnt_q <= 8'h00;
              cmp_cnt_q <= {6'h00, nbits};
              agr_cnt_q <= {6'h00, agree_n};
            end
          end
          ST_SCR: begin
            phase_cnt_q <= phase_nx;
            if (cmp_cnt_q < `RDSM_SYNC_WINDOW) begin
              cmp_cnt_q <= cmp_nx; // RULE_15
              agr_cnt_q <= agr_nx; // RULE_15
            end
            if (phase_nx >= `RDSM_SCR_BITS) begin
              phase_cnt_q <= 8'h00;
              if (agr_win > lock_thresh_q) begin
                st_q <= ST_LOCKED; // RULE_16
                o_locked <= 1'b1;
                o_sync_event <= 1'b1; // RULE_14 RULE_16
              end else begin
                st_q <= ST_DESC; // RULE_13
              end
            end
          end
          ST_LOCKED: begin
            st_q <= ST_LOCKED; // RULE_14
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Meters
  // --------------------------------------------------------------------------
  reg [15:0] interval_q, alarm_lim_q;
  reg [15:0] meter_tmr_q, alarm_tmr_q;
  reg [15:0] err_cnt_q, inner_cnt_q;
  reg [31:0] noise_acc_q, alarm_acc_q;
  reg [15:0] err_res_q, noise_res_q;
  reg [7:0] inner_res_q;
  wire [15:0] abs_err = o_slicer_err[15] ? (16'h0000 - o_slicer_err) : o_slicer_err;
  wire meter_end = (meter_tmr_q >= interval_q); // RULE_19
  wire alarm_end = (alarm_tmr_q >= i_alarm_period);
  wire [16:0] err_sum = {1'b0, err_cnt_q} + {15'h0000, hit_n};
  wire [15:0] err_sat = err_sum[16] ? 16'hffff : err_sum[15:0]; // RULE_18
  wire inner = o_symbol[0]; // RULE_20
  wire [15:0] inner_sat = (inner && inner_cnt_q != 16'hffff) ? inner_cnt_q + 16'h0001 : inner_cnt_q;
  wire [31:0] noise_nx = noise_acc_q + {16'h0000, abs_err}; // RULE_21
  wire [31:0] alarm_nx = alarm_acc_q + {16'h0000, abs_err}; // RULE_22

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meter_tmr_q <= 16'h0000;
      alarm_tmr_q <= 16'h0000;
      err_cnt_q <= 16'h0000;
      inner_cnt_q <= 16'h0000;
      noise_acc_q <= 32'h00000000;
      alarm_acc_q <= 32'h00000000;
      err_res_q <= 16'h0000;
      noise_res_q <= 16'h0000;
      inner_res_q <= 8'h00;
      o_alarm_event <= 1'b0;
    end else if (i_ce) begin
      o_alarm_event <= 1'b0;
      if (o_symbol_valid) begin
        if (meter_end) begin
          meter_tmr_q <= 16'h0000;
          err_res_q <= err_sat; // RULE_18
          inner_res_q <= inner_sat[15:8]; // RULE_20
          noise_res_q <= noise_nx[31:16]; // RULE_21
          err_cnt_q <= 16'h0000;
          inner_cnt_q <= 16'h0000;
          noise_acc_q <= 32'h00000000;
        end else begin
          meter_tmr_q <= meter_tmr_q + 16'h0001;
          err_cnt_q <= err_sat; // RULE_17
          inner_cnt_q <= inner_sat; // RULE_20
          noise_acc_q <= noise_nx;
        end
        if (alarm_end) begin
          alarm_tmr_q <= 16'h0000;
          alarm_acc_q <= 32'h00000000;
          o_alarm_event <= (alarm_nx[31:16] > alarm_lim_q); // RULE_22
        end else begin
          alarm_tmr_q <= alarm_tmr_q + 16'h0001;
          alarm_acc_q <= alarm_nx;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  reg [7:0] err_hi_latch_q, noise_hi_latch_q;
  reg [7:0] rd_mux;

  always @* begin
    case (i_reg_addr)
      `RDSM_OFS_INTERVAL_LO: rd_mux = interval_q[7:0];
      `RDSM_OFS_INTERVAL_HI: rd_mux = interval_q[15:8];
      `RDSM_OFS_LOCK_THRESH: rd_mux = lock_thresh_q;
      `RDSM_OFS_ALARM_LIM_LO: rd_mux = alarm_lim_q[7:0];
      `RDSM_OFS_ALARM_LIM_HI: rd_mux = alarm_lim_q[15:8];
      `RDSM_OFS_ERR_RATE_LO: rd_mux = err_res_q[7:0];
      `RDSM_OFS_ERR_RATE_HI: rd_mux = err_hi_latch_q; // RULE_24
      `RDSM_OFS_INNER_COUNT: rd_mux = inner_res_q;
      `RDSM_OFS_NOISE_LO: rd_mux = noise_res_q[7:0];
      `RDSM_OFS_NOISE_HI: rd_mux = noise_hi_latch_q; // RULE_24
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      interval_q <= `RDSM_RST_INTERVAL;
      lock_thresh_q <= `RDSM_RST_LOCK_THRESH;
      alarm_lim_q <= `RDSM_RST_ALARM_LIM;
      err_hi_latch_q <= 8'h00;
      noise_hi_latch_q <= 8'h00;
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
        if (i_reg_addr == `RDSM_OFS_ERR_RATE_LO) begin
          err_hi_latch_q <= err_res_q[15:8]; // RULE_24
        end
        if (i_reg_addr == `RDSM_OFS_NOISE_LO) begin
          noise_hi_latch_q <= noise_res_q[15:8]; // RULE_24
        end
      end
      if (i_reg_wr) begin
        case (i_reg_addr)
          `RDSM_OFS_INTERVAL_LO: interval_q[7:0] <= i_reg_wdata;
          `RDSM_OFS_INTERVAL_HI: interval_q[15:8] <= i_reg_wdata;
          `RDSM_OFS_LOCK_THRESH: lock_thresh_q <= i_reg_wdata;
          `RDSM_OFS_ALARM_LIM_LO: alarm_lim_q[7:0] <= i_reg_wdata;
          `RDSM_OFS_ALARM_LIM_HI: alarm_lim_q[15:8] <= i_reg_wdata;
          default: lock_thresh_q <= lock_thresh_q;
        endcase
      end
    end
  end

endmodule // rdsm_detector

/* pkg/rdsm_defs.vh */
// Constants for the receive detector, scrambler and meter block.
// Assumes an 8-bit register port and one symbol-rate strobe on the system clock.
`ifndef RDSM_DEFS_VH
`define RDSM_DEFS_VH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define RDSM_OFS_INTERVAL_LO 8'h18
`define RDSM_OFS_INTERVAL_HI 8'h19
`define RDSM_OFS_LOCK_THRESH 8'h2e
`define RDSM_OFS_ALARM_LIM_LO 8'h34
`define RDSM_OFS_ALARM_LIM_HI 8'h35
`define RDSM_OFS_ERR_RATE_HI 8'h40
`define RDSM_OFS_ERR_RATE_LO 8'h4c
`define RDSM_OFS_INNER_COUNT 8'h4e
`define RDSM_OFS_NOISE_LO 8'h50
`define RDSM_OFS_NOISE_HI 8'h51

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define RDSM_RST_INTERVAL 16'hffff
`define RDSM_RST_LOCK_THRESH 8'h60
`define RDSM_RST_ALARM_LIM 16'hffff

// --------------------------------------------------------------------------
// Shift register and lock sequence
// --------------------------------------------------------------------------
`define RDSM_LFSR_LEN 23
`define RDSM_TAP_SHORT 4
`define RDSM_TAP_CO 4
`define RDSM_TAP_RT 17
`define RDSM_TAP_LONG 22
`define RDSM_DESC_BITS 8'h17
`define RDSM_SCR_BITS 8'h7f
`define RDSM_SYNC_WINDOW 8'h80

// --------------------------------------------------------------------------
// Symbol codes as sign and magnitude bits
// --------------------------------------------------------------------------
`define RDSM_SYM_NEG3 2'h0
`define RDSM_SYM_NEG1 2'h1
`define RDSM_SYM_POS1 2'h3
`define RDSM_SYM_POS3 2'h2

`endif

/* tb/rdsm_detector_sva.sv */
// Assertion checker for the detector block ports.
// Assumes one clock domain with an active-low asynchronous reset.
module rdsm_detector_sva (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_sym_valid,
  input wire logic i_four_level,
  input wire logic i_lock_request,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [1:0] o_symbol,
  input wire logic o_symbol_valid,
  input wire logic [15:0] o_slicer_err,
  input wire logic [15:0] o_eq_err,
  input wire logic o_sync_event,
  input wire logic o_alarm_event,
  input wire logic o_locked,
  input wire logic o_lfsr_scrambling
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ------
  // Symbols taken while the lock request is high.
  // ------
  logic [7:0] req_syms_q;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_syms_q <= 8'h00;
    end else if (!i_lock_request) begin
      req_syms_q <= 8'h00;
    end else if (i_sym_valid && req_syms_q != 8'hff) begin
      req_syms_q <= req_syms_q + 8'h01;
    end
  end
  sequence s_req_dropped;
    $fell(i_lock_request);
  endsequence
  sequence s_two_level_out;
    !i_four_level [*8] ##0 o_symbol_valid;
  endsequence
  chk_symbol_cause: assert property (o_symbol_valid |-> $past(i_sym_valid))
    else $error("symbol output without a taken sample");
  chk_symbol_hold: assert property (!o_symbol_valid |-> $stable(o_symbol) &&
    $stable(o_slicer_err) && $stable(o_eq_err)) else $error("symbol outputs moved");
  chk_two_level_outer: assert property (s_two_level_out |-> !o_symbol[0])
    else $error("inner symbol in two-level mode");
  chk_sync_needs_req: assert property (o_sync_event |-> $past(i_lock_request))
    else $error("sync event without lock request");
  chk_sync_single: assert property (o_sync_event |=> !o_sync_event)
    else $error("sync event longer than one cycle");
  chk_lock_follows: assert property (o_sync_event |-> ##[0:1] o_locked)
    else $error("sync event without locked state");
  chk_locked_scrambles: assert property (o_locked |-> o_lfsr_scrambling)
    else $error("locked but not scrambling");
  chk_lock_span: assert property (o_sync_event |->
    req_syms_q >= (i_four_level ? 8'h46 : 8'h8c)) else $error("lock declared too early");
  chk_req_release: assert property (s_req_dropped |-> ##[1:2] !o_locked)
    else $error("lock held after request cleared");
  chk_alarm_single: assert property (o_alarm_event |=> !o_alarm_event)
    else $error("alarm event longer than one cycle");
  chk_rdata_hold: assert property (!$past(i_reg_rd) && !$past(i_reg_rd, 2)
    |-> $stable(o_reg_rdata)) else $error("read data moved without a read");
endmodule // rdsm_detector_sva

/* tb/rdsm_slicer_feed.sv */
// Model of the equalizer and slicer path feeding the detector.
// Assumes the system clock; drives on the falling edge, one sample every four cycles.
module rdsm_slicer_feed (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_mode,
  input wire logic i_four_level,
  input wire logic i_central_office,
  input wire logic [15:0] i_cursor,
  output logic o_valid,
  output logic [15:0] o_eq,
  output logic [15:0] o_ec,
  output logic [1:0] o_exp_code
);
  logic [22:0] hist_q;
  logic [1:0] gap_q, code_q;
  logic [2:0] ph_q;
  function automatic logic scr_bit(input logic [22:0] h, input logic co);
    scr_bit = ~(h[co ? 4 : 17] ^ h[22]);
  endfunction
  always @(negedge i_clk or negedge i_rstn) begin
    logic [22:0] h;
    logic b;
    logic [1:0] c;
    logic [15:0] v;
    if (!i_rstn) begin
      {hist_q, gap_q, code_q, ph_q} <= '0;
      {o_valid, o_eq, o_ec, o_exp_code} <= '0;
    end else begin
      gap_q <= gap_q + 2'h1;
      o_valid <= (gap_q == 2'h0);
      if (gap_q == 2'h0) begin
        h = {hist_q[21:0], scr_bit(hist_q, i_central_office)};
        b = scr_bit(h, i_central_office);
        hist_q <= i_four_level ? {h[21:0], b} : h;
        c = {h[0], i_four_level & b};
        if (i_mode == 2'h2) c = 2'h3;
        if (i_mode == 2'h1) c = (ph_q == 3'h1) ? 2'h2 : (ph_q == 3'h4) ? 2'h0 : {ph_q > 3'h2, 1'b0};
        case (c)
          2'h2: v = i_cursor;
          2'h3: v = i_cursor / 16'h0003 + 16'h0180;
          2'h1: v = -(i_cursor / 16'h0003);
          default: v = -i_cursor;
        endcase
        o_eq <= (i_mode == 2'h1) ? ((ph_q > 3'h2) ? 16'h0032 : 16'hffce) : v;
        o_ec <= (i_mode != 2'h1) ? v : (ph_q == 3'h1) ? 16'h0064 : (ph_q == 3'h4) ? 16'hff9c : 16'h0;
        ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
        code_q <= c;
        o_exp_code <= code_q;
      end
    end
  end
endmodule // rdsm_slicer_feed

/* tb/rdsm_detector_test.sv */
// Testbench for the detector block: registers, symbol path, lock sequence and meters.
// Assumes the feed model supplies samples; the checker is bound below the module.
module rdsm_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_rstn, i_sym_valid, o_symbol_valid, o_sync_event, o_alarm_event;
  logic o_locked, o_lfsr_scrambling, sym_chk = 1'b0;
  logic i_ce = 1'b1, i_four_level = 1'b0, i_two_level_startup = 1'b0, i_central_office = 1'b1;
  logic i_scramble_mode = 1'b0, i_lock_request = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [15:0] i_alarm_period = 16'h00ff, i_cursor_level = 16'h0900;
  logic [15:0] i_eq_sample, i_ec_sample, o_slicer_err, o_eq_err;
  logic [1:0] feed_mode = 2'h0, exp_code, o_symbol;
  int failures = 0, checked = 0, cycles = 0, syncs = 0, alarms = 0, seen = 0;
  rdsm_detector dut_u (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_sym_valid(i_sym_valid),
    .i_eq_sample(i_eq_sample), .i_ec_sample(i_ec_sample), .i_cursor_level(i_cursor_level),
    .i_four_level(i_four_level), .i_two_level_startup(i_two_level_startup),
    .i_central_office(i_central_office), .i_scramble_mode(i_scramble_mode),
    .i_lock_request(i_lock_request), .i_alarm_period(i_alarm_period), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_symbol(o_symbol), .o_symbol_valid(o_symbol_valid),
    .o_slicer_err(o_slicer_err), .o_eq_err(o_eq_err), .o_sync_event(o_sync_event),
    .o_alarm_event(o_alarm_event), .o_locked(o_locked), .o_lfsr_scrambling(o_lfsr_scrambling));
  rdsm_slicer_feed feed_u (
    .i_clk(i_sys_clk), .i_rstn(i_rstn), .i_mode(feed_mode), .i_four_level(i_four_level),
    .i_central_office(i_central_office), .i_cursor(i_cursor_level), .o_valid(i_sym_valid),
    .o_eq(i_eq_sample), .o_ec(i_ec_sample), .o_exp_code(exp_code));
  // ------
  // Clock, monitors and compare tasks.
  // ------
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic results;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp, input string what);
    check8({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    check8(got[15:8], exp[15:8], what);
    check8(got[7:0], exp[7:0], what);
  endtask
  always @(negedge i_sys_clk) begin
    cycles++;
    if (o_sync_event === 1'b1) syncs++;
    if (o_alarm_event === 1'b1) alarms++;
    if (sym_chk && o_symbol_valid === 1'b1) begin
      seen++;
      if (seen > 3) check8({6'h00, o_symbol}, {6'h00, exp_code}, "symbol");
    end
    if (cycles == 40000) begin
      failures++;
      $display("MISMATCH %0t run did not finish", $time);
      results;
    end
  end
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    @(negedge i_sys_clk);
    check8(o_reg_rdata, exp, "register");
  endtask
  task automatic run_syms(input logic [1:0] m, input logic fl, input logic st);
    seen = 0;
    feed_mode = m;
    i_four_level = fl;
    i_two_level_startup = st;
    sym_chk = 1'b1;
    repeat (160) @(negedge i_sys_clk);
    sym_chk = 1'b0;
  endtask
  task automatic lock_try(input logic fl, input logic co, input logic [7:0] th, input logic hit);
    reg_write(8'h2e, th);
    i_lock_request = 1'b0;
    i_four_level = fl;
    i_central_office = co;
    feed_mode = 2'h0;
    repeat (200) @(negedge i_sys_clk);
    syncs = 0;
    i_lock_request = 1'b1;
    for (int n = 0; n < 1600 && syncs == 0; n++) @(negedge i_sys_clk);
    repeat (200) @(negedge i_sys_clk);
    check8(syncs[7:0], {7'h00, hit}, "sync events");
    check1(o_locked, hit, "locked");
    check1(o_lfsr_scrambling | ~hit, 1'b1, "scrambling");
  endtask
  task automatic ber_check;
    repeat (5400) @(negedge i_sys_clk);
    reg_check(8'h4c, 8'h80);
    reg_check(8'h40, 8'h02);
  endtask
  // ------
  // Main sequence.
  // ------
  initial begin
    logic [7:0] ra [6] = '{8'h18, 8'h19, 8'h2e, 8'h34, 8'h35, 8'h00};
    logic [7:0] rv [6] = '{8'hff, 8'hff, 8'h60, 8'hff, 8'hff, 8'h00};
    i_rstn = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    foreach (ra[i]) reg_check(ra[i], rv[i]);
    reg_write(8'h4e, 8'h5a);
    reg_check(8'h4e, 8'h00);
    reg_write(8'h2e, 8'h3c);
    reg_check(8'h2e, 8'h3c);
    run_syms(2'h0, 1'b0, 1'b0);
    run_syms(2'h0, 1'b1, 1'b0);
    run_syms(2'h1, 1'b0, 1'b1);
    i_two_level_startup = 1'b0;
    reg_write(8'h18, 8'h7f);
    reg_write(8'h19, 8'h02);
    lock_try(1'b0, 1'b1, 8'h80, 1'b0);
    lock_try(1'b1, 1'b0, 8'h7f, 1'b1);
    lock_try(1'b0, 1'b1, 8'h7f, 1'b1);
    ber_check;
    i_lock_request = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    check1(o_locked, 1'b0, "locked after clear");
    check1(o_lfsr_scrambling, 1'b0, "descrambling after clear");
    ber_check;
    i_scramble_mode = 1'b1;
    ber_check;
    check1(o_lfsr_scrambling, 1'b1, "free scrambler");
    feed_mode = 2'h2;
    i_four_level = 1'b1;
    reg_write(8'h34, 8'h00);
    reg_write(8'h35, 8'h00);
    repeat (5400) @(negedge i_sys_clk);
    check16(o_slicer_err, 16'h0180, "slicer error");
    check16(o_eq_err, 16'h0180, "equalizer error");
    reg_check(8'h4e, 8'h02);
    reg_check(8'h50, 8'h03);
    reg_check(8'h51, 8'h00);
    alarms = 0;
    repeat (2100) @(negedge i_sys_clk);
    check1(alarms >= 2, 1'b1, "alarm raised");
    reg_write(8'h34, 8'h01);
    repeat (1100) @(negedge i_sys_clk);
    alarms = 0;
    repeat (2100) @(negedge i_sys_clk);
    check1(alarms == 0, 1'b1, "alarm at limit");
    results;
  end
endmodule // rdsm_detector_test
bind rdsm_detector rdsm_detector_sva chk_u (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sym_valid(i_sym_valid),
  .i_four_level(i_four_level), .i_lock_request(i_lock_request), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_symbol(o_symbol), .o_symbol_valid(o_symbol_valid),
  .o_slicer_err(o_slicer_err), .o_eq_err(o_eq_err), .o_sync_event(o_sync_event),
  .o_alarm_event(o_alarm_event), .o_locked(o_locked), .o_lfsr_scrambling(o_lfsr_scrambling));
